// file: eep_consts.svh
// eep_consts.svh: clock and timing figures, widths, opcodes and array shape of the serial memory block
// assumes it is included by bare name from every file that needs the figures
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

// system clock rate and self-timed programming time
`define EEP_CLK_MHZ       100
`define EEP_PROG_TIME_US  5000
// least select low time the host keeps between frames; the device does not police it
`define EEP_SELECT_LOW_NS 250

// address and data widths for the two organizations
`define EEP_AW_BYTE       5'd7
`define EEP_AW_WORD       5'd6
`define EEP_DW_BYTE       5'd8
`define EEP_DW_WORD       5'd16

// two-bit opcodes and the qualifier codes of opcode zero
`define EEP_OP_READ       2'h2
`define EEP_OP_WRITE      2'h1
`define EEP_OP_ERASE      2'h3
`define EEP_OP_QUAL       2'h0
`define EEP_Q_ENABLE      2'h3
`define EEP_Q_ERASE_ALL   2'h2
`define EEP_Q_WRITE_ALL   2'h1
`define EEP_Q_DISABLE     2'h0

// array shape and erased value
`define EEP_BYTES         128
`define EEP_ERASED        8'hff

`endif

// file: eep_pkg.sv
// eep_pkg.sv: types shared by the serial memory block
// assumes nothing beyond a SystemVerilog compiler
package eep_pkg;

  // sequencer states of one framed instruction
  typedef enum logic [2:0] {
    EEP_ST_IDLE,   // select low, link ignored
    EEP_ST_START,  // select high, waiting for the start bit
    EEP_ST_ADDR,   // shifting opcode and address
    EEP_ST_DATA,   // shifting write data
    EEP_ST_READ,   // shifting the read word out
    EEP_ST_HOLD    // instruction done, waiting for select low
  } eep_state_t;

  // decoded instruction
  typedef enum logic [2:0] {
    EEP_CMD_READ,
    EEP_CMD_WRITE,
    EEP_CMD_ERASE,
    EEP_CMD_PROGRAM_ENABLE,
    EEP_CMD_PROGRAM_DISABLE,
    EEP_CMD_ERASE_ALL,
    EEP_CMD_WRITE_ALL
  } eep_cmd_t;

endpackage

// file: eep_sync.sv
// eep_sync.sv: three-stage synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to clk_in; output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module eep_sync #(
  parameter int unsigned WIDTH = 4  // number of pins carried
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_r;  // metastable stage, read only by stage2
  logic [WIDTH-1:0] stage2_r;  // first settled copy
  logic [WIDTH-1:0] stage3_r;  // second settled copy

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("eep_sync needs at least one bit");
    end
  endgenerate

  // three flops in a row; reset to zero so select reads low after reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // a bit moves only once two settled stages agree, filtering single-sample glitches
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_filter
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          level_out[i] <= 1'b0;
        end else if (stage2_r[i] == stage3_r[i]) begin
          level_out[i] <= stage3_r[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// file: eep_serial_core.sv
// eep_serial_core.sv: instruction decoder, sequencer and array of a 1 Kbit three-wire serial memory
// assumes select, shift clock, data in and strap arrive from pins and are sampled by clk_in;
// the output pair data_out_out / data_out_oe_out is resolved into a three-state pin outside
`timescale 1ns/1ps
`default_nettype none

`include "eep_consts.svh"

// Contract
// - frame: select rise, start one, opcode, address
// - read word driven out on clock rises
// - dummy zero precedes 8 or 16 data bits
// - power-up leaves programming disabled
// - enable holds until disable or power loss
// - erase sets word to ones after decode
// - write programs after last data bit
// - select low, then high shows status
// - status low while busy, high when ready
// - no status once programming already finished
// - erase-all sets whole array to ones
// - write-all programs every word with pattern
// - disable blocks all erase and write
// - read works enabled or disabled
// - opcode and qualifier decoding, 7/6 address bits
// - strap high selects 16-bit, low 8-bit
module eep_serial_core
  import eep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `EEP_PROG_TIME_US * `EEP_CLK_MHZ  // self-timed length
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,               // power-up reset
  input  wire logic select_in,                // chip select pin
  input  wire logic shift_clock_in,           // link shift clock pin
  input  wire logic serial_in,                // serial data in pin
  input  wire logic organization_strap_in,    // high: 16-bit words, low: 8-bit words
  output var  logic data_out_out,             // serial data out level
  output var  logic data_out_oe_out,          // high while data out is driven
  output var  logic busy_out                  // self-timed cycle in progress
);

  localparam int unsigned CW = 20;  // width of the programming counter

  generate
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << CW)) begin : g_bad_prog
      $error("PROG_CYCLES out of range of the programming counter");
    end
  endgenerate

  // synchronised pin levels
  logic [3:0] pins_w;
  logic       strap_w;   // filtered strap level
  logic       cs_w;      // filtered select level
  logic       sk_w;      // filtered shift clock level
  logic       di_w;      // filtered data in level

  eep_sync #(.WIDTH(4)) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({organization_strap_in, select_in, shift_clock_in, serial_in}),
    .level_out  (pins_w)
  );

  assign strap_w = pins_w[3];
  assign cs_w    = pins_w[2];
  assign sk_w    = pins_w[1];
  assign di_w    = pins_w[0];

  // state
  eep_state_t     state_r;                   // sequencer state
  eep_cmd_t       cmd_r;                     // instruction awaiting its data
  logic           sk_q_r;                    // shift clock one sample back
  logic           cs_q_r;                    // select one sample back
  logic           org16_r;                   // organization latched at frame start
  logic           enable_r;                  // programming enabled
  logic           status_r;                  // ready/busy shown on data out
  logic           rd_oe_r;                   // read data driven
  logic           dout_r;                    // read bit on data out
  logic [15:0]    sh_r;                      // input shift register
  logic [15:0]    out_r;                     // read word shift register
  logic [4:0]     cnt_r;                     // bits shifted in current field
  logic [6:0]     addr_r;                    // address held for a write
  logic [CW-1:0]  prog_cnt_r;                // self-timed cycle countdown
  logic           busy_r;                    // self-timed cycle in progress
  logic [7:0]     mem_r [`EEP_BYTES];        // the array; no reset, it is nonvolatile

  // edges of the sampled link signals
  wire sk_rise = sk_w & ~sk_q_r;
  wire cs_rise = cs_w & ~cs_q_r;

  // shifted value including the bit arriving now
  wire [15:0] sh_nxt = {sh_r[14:0], di_w};

  // widths for the frame's organization
  wire [4:0] aw_w = org16_r ? `EEP_AW_WORD : `EEP_AW_BYTE;
  wire [4:0] dw_w = org16_r ? `EEP_DW_WORD : `EEP_DW_BYTE;

  // opcode, qualifier and address fields as they stand at the last address bit
  wire [1:0] op_w   = org16_r ? sh_nxt[7:6] : sh_nxt[8:7];
  wire [1:0] qual_w = org16_r ? sh_nxt[5:4] : sh_nxt[6:5];
  wire [6:0] adr_w  = org16_r ? {1'b0, sh_nxt[5:0]} : sh_nxt[6:0];

  // decode opcode and qualifier into an instruction
  function automatic eep_cmd_t decode(input logic [1:0] op, input logic [1:0] qual);
    eep_cmd_t c;
    c = EEP_CMD_PROGRAM_DISABLE;
    unique case (op)
      `EEP_OP_READ:  c = EEP_CMD_READ;
      `EEP_OP_WRITE: c = EEP_CMD_WRITE;
      `EEP_OP_ERASE: c = EEP_CMD_ERASE;
      `EEP_OP_QUAL: begin
        unique case (qual)
          `EEP_Q_ENABLE:    c = EEP_CMD_PROGRAM_ENABLE;
          `EEP_Q_ERASE_ALL: c = EEP_CMD_ERASE_ALL;
          `EEP_Q_WRITE_ALL: c = EEP_CMD_WRITE_ALL;
          `EEP_Q_DISABLE:   c = EEP_CMD_PROGRAM_DISABLE;
        endcase
      end
    endcase
    return c;
  endfunction

  eep_cmd_t  cmd_w;
  assign cmd_w = decode(op_w, qual_w);

  // frame milestones on a sampled shift clock rise
  wire       live_w     = cs_w & sk_rise;
  wire       start_w    = live_w & (state_r == EEP_ST_START) & di_w & ~busy_r;
  wire       addr_end_w = live_w & (state_r == EEP_ST_ADDR) & (cnt_r == aw_w + 5'd1);
  wire       data_end_w = live_w & (state_r == EEP_ST_DATA) & (cnt_r == dw_w - 5'd1);

  // programming launches: erase at decode, write after its last data bit
  wire erase_go_w = addr_end_w & enable_r &
                    ((cmd_w == EEP_CMD_ERASE) | (cmd_w == EEP_CMD_ERASE_ALL));
  wire write_go_w = data_end_w & enable_r;
  wire prog_go_w  = erase_go_w | write_go_w;

  // array write controls
  wire        mem_all_w  = erase_go_w ? (cmd_w == EEP_CMD_ERASE_ALL)
                                      : (cmd_r == EEP_CMD_WRITE_ALL);
  wire [6:0]  mem_adr_w  = erase_go_w ? adr_w : addr_r;
  wire [15:0] mem_dat_w  = erase_go_w ? {`EEP_ERASED, `EEP_ERASED}
                                      : (org16_r ? sh_nxt : {8'h00, sh_nxt[7:0]});

  // word read at decode; in 16-bit mode the odd byte is the high half
  wire [7:0]  rd_lo_w    = org16_r ? mem_r[{adr_w[5:0], 1'b0}] : mem_r[adr_w];
  wire [7:0]  rd_hi_w    = mem_r[{adr_w[5:0], 1'b1}];
  wire [15:0] rd_word_w  = org16_r ? {rd_hi_w, rd_lo_w} : {rd_lo_w, 8'h00};  // msb aligned

  // array update; erase-all and write-all touch every byte in the same cycle
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < `EEP_BYTES; i++) begin
      if (prog_go_w) begin
        if (mem_all_w) begin
          mem_r[i] <= (org16_r && i[0]) ? mem_dat_w[15:8] : mem_dat_w[7:0];
        end else if (org16_r ? (i[6:1] == mem_adr_w[5:0]) : (i[6:0] == mem_adr_w)) begin
          mem_r[i] <= (org16_r && i[0]) ? mem_dat_w[15:8] : mem_dat_w[7:0];
        end
      end
    end
  end

  // self-timed cycle; the array is already updated, the count models the busy time
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prog_cnt_r <= '0;
      busy_r     <= 1'b0;
    end else if (prog_go_w) begin
      prog_cnt_r <= CW'(PROG_CYCLES);
      busy_r     <= 1'b1;
    end else if (busy_r) begin
      prog_cnt_r <= prog_cnt_r - CW'(1);
      busy_r     <= (prog_cnt_r != CW'(1));
    end
  end

  // programming enable flag; only a full enable or disable instruction moves it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enable_r <= 1'b0;
    end else if (addr_end_w && cmd_w == EEP_CMD_PROGRAM_ENABLE) begin
      enable_r <= 1'b1;
    end else if (addr_end_w && cmd_w == EEP_CMD_PROGRAM_DISABLE) begin
      enable_r <= 1'b0;
    end
  end

  // edge history of the link signals
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sk_q_r <= 1'b0;
      cs_q_r <= 1'b0;
    end else begin
      sk_q_r <= sk_w;
      cs_q_r <= cs_w;
    end
  end

  // status: armed at select rise only if a cycle is still running, so a late
  // rise after completion shows nothing; a start bit once ready ends it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !cs_w) begin
      status_r <= 1'b0;
    end else if (cs_rise) begin
      status_r <= busy_r;
    end else if (start_w) begin
      status_r <= 1'b0;
    end
  end

  // instruction sequencer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !cs_w) begin
      state_r <= EEP_ST_IDLE;
      cmd_r   <= EEP_CMD_READ;
      org16_r <= 1'b1;
      rd_oe_r <= 1'b0;
      dout_r  <= 1'b0;
      sh_r    <= '0;
      out_r   <= '0;
      cnt_r   <= '0;
      addr_r  <= '0;
    end else begin
      unique case (state_r)
        EEP_ST_IDLE: begin
          if (cs_rise) begin
            state_r <= EEP_ST_START;
            org16_r <= strap_w;
          end
        end
        EEP_ST_START: begin
          if (start_w) begin
            state_r <= EEP_ST_ADDR;
            sh_r    <= '0;
            cnt_r   <= '0;
          end
        end
        EEP_ST_ADDR: begin
          if (live_w) begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_r + 5'd1;
          end
          if (addr_end_w) begin
            cnt_r  <= '0;
            addr_r <= adr_w;
            cmd_r  <= cmd_w;
            if (cmd_w == EEP_CMD_READ) begin
              state_r <= EEP_ST_READ;
              out_r   <= rd_word_w;
              dout_r  <= 1'b0;
              rd_oe_r <= 1'b1;
            end else if (cmd_w == EEP_CMD_WRITE || cmd_w == EEP_CMD_WRITE_ALL) begin
              state_r <= EEP_ST_DATA;
            end else begin
              state_r <= EEP_ST_HOLD;
            end
          end
        end
        EEP_ST_DATA: begin
          if (live_w) begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_r + 5'd1;
          end
          if (data_end_w) begin
            state_r <= EEP_ST_HOLD;
          end
        end
        EEP_ST_READ: begin
          if (live_w) begin
            dout_r <= out_r[15];
            out_r  <= {out_r[14:0], 1'b0};                                // zeros after the word
          end
        end
        EEP_ST_HOLD: begin
          state_r <= EEP_ST_HOLD;                                         // wait for select low
        end
      endcase
    end
  end

  // data out: status wins over read data; released while select is low
  assign data_out_out    = status_r ? ~busy_r : dout_r;
  assign data_out_oe_out = status_r | rd_oe_r;
  assign busy_out        = busy_r;

endmodule

`default_nettype wire

// file: eep_serial_core_monitor.sv
// eep_serial_core_monitor.sv: port checks of the serial memory core
// assumes a bind to eep_serial_core; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module eep_serial_core_monitor #(
  parameter int unsigned PROG_CYCLES = 200  // self-timed length in clk
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic select_in,
  input wire logic shift_clock_in,
  input wire logic serial_in,
  input wire logic organization_strap_in,
  input wire logic data_out_out,
  input wire logic data_out_oe_out,
  input wire logic busy_out
);
  logic [19:0] busy_r;  // busy cycles so far
  logic [3:0]  age_r;   // clk since the shift pin rose, saturating
  logic        sk_r;    // shift pin one clk back
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // busy count cleared and shift age set to its saturated value in reset, so no property sees a stale count
  always_ff @(posedge clk_in) begin
    sk_r   <= shift_clock_in;
    busy_r <= (busy_out && !sys_rst_in) ? busy_r + 20'h0_0001 : 20'h0_0000;
    if (sys_rst_in || (shift_clock_in && !sk_r)) begin
      age_r <= sys_rst_in ? 4'hf : 4'h0;
    end else if (age_r != 4'hf) begin
      age_r <= age_r + 4'h1;
    end
  end
  reset_quiet_a: assert property ($past(sys_rst_in) |-> !data_out_oe_out && !busy_out)
    else $error("output active after reset");
  pin_release_a: assert property (!select_in [*8] |-> !data_out_oe_out)
    else $error("data out driven while deselected");
  prog_length_a: assert property ($fell(busy_out) |-> busy_r == PROG_CYCLES)
    else $error("self-timed cycle length wrong");
  busy_low_a: assert property (data_out_oe_out && busy_out |-> !data_out_out)
    else $error("status high while busy");
  ready_high_a: assert property ($fell(busy_out) && data_out_oe_out |-> ##[0:2] data_out_out)
    else $error("status not high when ready");
  late_status_a: assert property (!busy_out [*8] ##1 $rose(select_in) |-> !data_out_oe_out [*8])
    else $error("status shown after cycle ended");
  read_edge_a: assert property (data_out_oe_out && $past(data_out_oe_out) && $changed(data_out_out)
    && !$past(busy_out) && !$past(busy_out, 2) |-> age_r inside {[2:10]})
    else $error("data out moved away from a shift rise");
  busy_start_a: assert property ($rose(busy_out) |-> select_in && age_r <= 4'ha)
    else $error("cycle not started at last bit");
  oe_select_a: assert property ($rose(data_out_oe_out) |-> select_in)
    else $error("data out driven without select");
endmodule
`default_nettype wire

// file: eep_host_model.sv
// eep_host_model.sv: host side of the three-wire link
// assumes the bench resolves data out into one pin level fed back here
`timescale 1ns/1ps
`default_nettype none
module eep_host_model (
  output var  logic select_out,      // chip select
  output var  logic shift_clock_out, // shift clock, still outside frames
  output var  logic serial_out,      // data toward the device
  input  wire logic data_pin_in      // resolved data out pin
);
  initial begin
    select_out = 1'b0;
    shift_clock_out = 1'b0;
    serial_out = 1'b0;
  end
  // n bits msb first at a 125 ns period; the pin is read just before each rise
  task automatic shift(input logic [31:0] bits, input int n, output logic [31:0] got);
    got = 32'h0000_0000;
    for (int i = n - 1; i >= 0; i--) begin
      serial_out = bits[i];
      #62.5;
      got = {got[30:0], data_pin_in};
      shift_clock_out = 1'b1;
      #62.5;
      shift_clock_out = 1'b0;
    end
  endtask
  // select rises with the shift clock low
  task automatic open_frame();
    select_out = 1'b1;
    #62.5;
  endtask
  // select then stays low longer than the least low time
  task automatic close_frame();
    #62.5;
    select_out = 1'b0;
    #300;
  endtask
endmodule
`default_nettype wire

// file: eep_serial_core_tb.sv
// eep_serial_core_tb.sv: self-checking bench of the serial memory core
// assumes eep_host_model plays the host; short self-timed cycle
`timescale 1ns/1ps
`default_nettype none
`include "eep_consts.svh"
`define EEP_CHECK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module eep_serial_core_tb;
  localparam int unsigned PROG = 300;  // short cycle keeps the run brief
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;      // power-up reset
  logic        org_r = 1'b1;           // strap, high is 16-bit words
  logic        en_r = 1'b0;            // expected programming enable
  logic        tgl_r = 1'b0;           // what a floating pin shows
  logic        sel, sk, sdi, dout, doe, busy;
  logic [7:0]  mem [128];              // expected array bytes
  logic [31:0] seed = 32'h0790_b00e;
  int          miscompares = 0;
  int          checked = 0;
  wire         pin = doe ? dout : tgl_r; // a released pin keeps no level

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) tgl_r <= ~tgl_r;

  eep_serial_core #(.PROG_CYCLES(PROG)) i_eep_serial_core (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .select_in(sel), .shift_clock_in(sk), .serial_in(sdi),
    .organization_strap_in(org_r), .data_out_out(dout), .data_out_oe_out(doe),
    .busy_out(busy));
  eep_host_model i_eep_host_model (.select_out(sel), .shift_clock_out(sk),
    .serial_out(sdi), .data_pin_in(pin));

  // word the array should hold at an address
  function automatic logic [15:0] exp_word(input logic [6:0] a);
    return org_r ? {mem[{a[5:0], 1'b1}], mem[{a[5:0], 1'b0}]} : {8'h00, mem[a]};
  endfunction
  // address field of an opcode-zero command, with don't-care bits filled
  function automatic logic [6:0] qa(input logic [1:0] q);
    return org_r ? {1'b0, q, 4'h9} : {q, 5'h12};
  endfunction
  task automatic set_org(input logic v);
    @(posedge clk_in);
    #1 org_r = v;
  endtask
  // one framed instruction; lengths follow the strap
  task automatic instr(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
                       output logic [15:0] w);
    int          aw;
    int          dw;
    logic [1:0]  q;
    logic [31:0] got;
    aw = org_r ? 6 : 7;
    dw = org_r ? 16 : 8;
    q  = org_r ? a[5:4] : a[6:5];
    w  = 16'h0000;
    i_eep_host_model.open_frame();
    i_eep_host_model.shift((32'({1'b1, op}) << aw) | 32'(a), 3 + aw, got);
    if (op == `EEP_OP_WRITE || (op == `EEP_OP_QUAL && q == `EEP_Q_WRITE_ALL))
      i_eep_host_model.shift(32'(d), dw, got);
    if (op == `EEP_OP_READ) begin
      i_eep_host_model.shift(32'h0000_0000, dw + 1, got);
      `EEP_CHECK(got[dw], 1'b0)
      w = got[15:0];
    end
    i_eep_host_model.close_frame();
  endtask
  task automatic chk(input logic [6:0] a);
    logic [15:0] w;
    instr(`EEP_OP_READ, a, 16'h0000, w);
    `EEP_CHECK(w, exp_word(a))
  endtask
  // status seen busy, then ready
  task automatic status();
    i_eep_host_model.open_frame();
    repeat (10) @(posedge clk_in);
    `EEP_CHECK(pin, 1'b0)
    for (int n = 0; n < 1000 && busy !== 1'b0; n++) @(posedge clk_in);
    repeat (10) @(posedge clk_in);
    `EEP_CHECK(pin, 1'b1)
    i_eep_host_model.close_frame();
  endtask
  // programming command; late asks for select only after the cycle
  task automatic prog(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
                      input logic late);
    logic [15:0] w;
    logic [1:0]  q;
    q = org_r ? a[5:4] : a[6:5];
    instr(op, a, d, w);
    if (!en_r) begin
      repeat (20) @(posedge clk_in);
      `EEP_CHECK(busy, 1'b0)
    end else begin
      for (int i = 0; i < 128; i++) begin
        if (op == `EEP_OP_QUAL || (org_r ? i[6:1] == a[5:0] : i[6:0] == a))
          mem[i] = (op == `EEP_OP_WRITE || op == `EEP_OP_QUAL && q == `EEP_Q_WRITE_ALL)
                   ? ((i[0] && org_r) ? d[15:8] : d[7:0]) : `EEP_ERASED;
      end
      if (late) begin
        repeat (PROG + 50) @(posedge clk_in);
        i_eep_host_model.open_frame();
        repeat (10) @(posedge clk_in);
        `EEP_CHECK(doe, 1'b0)
        i_eep_host_model.close_frame();
      end else status();
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [15:0] w;
    logic [31:0] r;
    logic [6:0]  a;
    repeat (2) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    repeat (10) @(posedge clk_in);
    prog(`EEP_OP_QUAL, qa(`EEP_Q_ERASE_ALL), 16'h0000, 1'b0);
    instr(`EEP_OP_QUAL, qa(`EEP_Q_ENABLE), 16'h0000, w);
    en_r = 1'b1;
    prog(`EEP_OP_QUAL, qa(`EEP_Q_ERASE_ALL), 16'h0000, 1'b0);
    chk(7'h3f);
    prog(`EEP_OP_QUAL, qa(`EEP_Q_WRITE_ALL), 16'ha5c3, 1'b0);
    chk(7'h21);
    set_org(1'b0);
    chk(7'h7f);
    // random writes, erases and reads under both straps
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      set_org(r[2]);
      a = r[9:3] & (r[2] ? 7'h3f : 7'h7f);
      if (r[0]) prog(r[1] ? `EEP_OP_WRITE : `EEP_OP_ERASE, a, r[31:16], 1'b0);
      chk(a);
    end
    // frame cut short inside the data bits is dropped
    set_org(1'b1);
    i_eep_host_model.open_frame();
    i_eep_host_model.shift(32'h0000_0a2d, 12, r);
    i_eep_host_model.close_frame();
    repeat (20) @(posedge clk_in);
    `EEP_CHECK(busy, 1'b0)
    chk(7'h05);
    prog(`EEP_OP_WRITE, 7'h09, 16'h3c5a, 1'b1);
    chk(7'h09);
    instr(`EEP_OP_QUAL, qa(`EEP_Q_DISABLE), 16'h0000, w);
    en_r = 1'b0;
    prog(`EEP_OP_WRITE, 7'h09, 16'h0000, 1'b0);
    prog(`EEP_OP_ERASE, 7'h09, 16'h0000, 1'b0);
    chk(7'h09);
    conclude();
  end
  // about 50 frames of a few us each; this leaves ample margin
  initial begin
    #900_000;
    miscompares++;
    conclude();
  end
endmodule
bind eep_serial_core eep_serial_core_monitor #(.PROG_CYCLES(PROG_CYCLES))
  i_eep_serial_core_monitor (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .select_in(select_in), .shift_clock_in(shift_clock_in), .serial_in(serial_in),
  .organization_strap_in(organization_strap_in), .data_out_out(data_out_out),
  .data_out_oe_out(data_out_oe_out), .busy_out(busy_out));
`default_nettype wire
